// [logic/phy_mgmt_pkg.sv]
// constants of the transceiver basic management register set
package phy_mgmt_pkg;
	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_CONTROL = 4'h0;
	localparam logic [3:0] IDX_STATUS = 4'h1;
	localparam logic [3:0] IDX_IDENT_HIGH = 4'h2;
	localparam logic [3:0] IDX_IDENT_LOW = 4'h3;
	localparam logic [3:0] IDX_ADVERTISE = 4'h4;
	localparam logic [3:0] IDX_PARTNER = 4'h5;
	localparam logic [3:0] IDX_EXPANSION = 4'h6;
	localparam logic [3:0] IDX_UNSUPPORTED = 4'h7;
	// basic_mode_control bit positions
	localparam int CTL_RESET = 15;
	localparam int CTL_LOOPBACK = 14;
	localparam int CTL_SPEED = 13;
	localparam int CTL_AUTONEG = 12;
	localparam int CTL_POWER_DOWN = 11;
	localparam int CTL_ISOLATE = 10;
	localparam int CTL_RESTART = 9;
	localparam int CTL_DUPLEX = 8;
	localparam int CTL_COLL_TEST = 7;
	// basic_mode_status bit positions
	localparam int STS_AN_DONE = 5;
	localparam int STS_REMOTE_FAULT = 4;
	localparam int STS_LINK = 2;
	localparam int STS_JABBER = 1;
	// reset values, fixed status value, write mask and isolate strap address
	localparam logic [15:0] CTL_RESET_VALUE = 16'h3100;
	localparam logic [15:0] STS_FIXED_VALUE = 16'h7809;
	localparam logic [15:0] ADV_RESET_VALUE = 16'h01e1;
	localparam logic [15:0] ADV_WRITE_MASK = 16'h25ff;
	localparam logic [4:0] STRAP_ISOLATE_ADDRESS = 5'h00;
endpackage : phy_mgmt_pkg

// [logic/phy_basic_mgmt_registers.sv]
// apb register bank of the transceiver basic management registers
`timescale 1ns/1ps

module phy_basic_mgmt_registers #(
	parameter logic [15:0] IDENT_HIGH = 16'h1234, // arbitrary value
	parameter logic [15:0] IDENT_LOW = 16'h5678 // arbitrary value
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [4:0] strapped_transceiver_address,
	input wire logic link_up,
	input wire logic jabber_event,
	input wire logic remote_fault_event,
	input wire logic autoneg_done,
	input wire logic negotiated_speed_100,
	input wire logic negotiated_full_duplex,
	input wire logic [15:0] partner_word,
	output logic loopback_en,
	output logic power_down,
	output logic isolate,
	output logic collision_test,
	output logic autoneg_en,
	output logic link_speed_100,
	output logic link_full_duplex,
	output logic soft_reset_pulse,
	output logic restart_pulse
);

	typedef struct packed {
		logic loopback;
		logic speed_100;
		logic autoneg;
		logic power_down;
		logic isolate;
		logic full_duplex;
		logic coll_test;
		logic isolate_default;
		logic soft_reset;
		logic restart;
		logic op_speed_100;
		logic op_full_duplex;
		logic [15:0] advertise;
		logic link_latched;
		logic jabber_latched;
		logic fault_latched;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_s;

	state_s state;
	state_s next_state;
	logic setup;
	logic done;
	logic mapped;
	logic [3:0] idx;
	logic status_read;
	logic [15:0] control_word;
	logic [15:0] status_word;
	logic [15:0] read_word;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	assign setup = psel & ~penable;
	assign done = psel & penable & state.pready;
	assign idx = paddr[5:2];
	assign mapped = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00);
	assign status_read = done & ~pwrite & mapped
		& (idx == phy_mgmt_pkg::IDX_STATUS);

	////////////////////////////////////////////////////////////////////////
	// read words

	always_comb begin
		control_word = 16'h0000;
		control_word[phy_mgmt_pkg::CTL_LOOPBACK] = state.loopback;
		control_word[phy_mgmt_pkg::CTL_SPEED] = state.speed_100;
		control_word[phy_mgmt_pkg::CTL_AUTONEG] = state.autoneg;
		control_word[phy_mgmt_pkg::CTL_POWER_DOWN] = state.power_down;
		control_word[phy_mgmt_pkg::CTL_ISOLATE] = state.isolate;
		control_word[phy_mgmt_pkg::CTL_DUPLEX] = state.full_duplex;
		control_word[phy_mgmt_pkg::CTL_COLL_TEST] = state.coll_test;
		// fixed capability bits, preamble bit 0, reserved 0
		status_word = phy_mgmt_pkg::STS_FIXED_VALUE;
		status_word[phy_mgmt_pkg::STS_AN_DONE] = autoneg_done;
		status_word[phy_mgmt_pkg::STS_REMOTE_FAULT] = state.fault_latched;
		status_word[phy_mgmt_pkg::STS_LINK] = state.link_latched;
		status_word[phy_mgmt_pkg::STS_JABBER] = state.jabber_latched;
		read_word = 16'h0000;
		unique case (idx)
			phy_mgmt_pkg::IDX_CONTROL: read_word = control_word;
			phy_mgmt_pkg::IDX_STATUS: read_word = status_word;
			phy_mgmt_pkg::IDX_IDENT_HIGH: read_word = IDENT_HIGH;
			phy_mgmt_pkg::IDX_IDENT_LOW: read_word = IDENT_LOW;
			phy_mgmt_pkg::IDX_ADVERTISE: read_word = state.advertise;
			phy_mgmt_pkg::IDX_PARTNER: read_word = partner_word;
			phy_mgmt_pkg::IDX_EXPANSION: read_word = 16'h0000;
			default: read_word = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_state = state;
		next_state.soft_reset = 1'b0;
		next_state.restart = 1'b0;
		// apb: no wait state, data and error captured at setup
		if (setup) begin
			next_state.pready = 1'b1;
			next_state.pslverr = ~mapped;
			next_state.prdata = (mapped && !pwrite) ? {16'h0000, read_word}
				: 32'h0000_0000;
		end else if (done) begin
			next_state.pready = 1'b0;
			next_state.pslverr = 1'b0;
		end
		// latch-low link, latch-high jabber and fault
		next_state.link_latched = link_up
			& (state.link_latched | status_read);
		next_state.jabber_latched = jabber_event | (state.jabber_latched
			& ~(status_read & state.prdata[phy_mgmt_pkg::STS_JABBER]));
		next_state.fault_latched = remote_fault_event | (state.fault_latched
			& ~(status_read
			& state.prdata[phy_mgmt_pkg::STS_REMOTE_FAULT]));
		if (done && pwrite && mapped && idx == phy_mgmt_pkg::IDX_CONTROL) begin
			if (pwdata[phy_mgmt_pkg::CTL_RESET]) begin
				// soft reset restores every writable default
				next_state.soft_reset = 1'b1;
				next_state.loopback = 1'b0;
				next_state.speed_100 = 1'b1;
				next_state.autoneg = 1'b1;
				next_state.power_down = 1'b0;
				next_state.isolate = state.isolate_default;
				next_state.full_duplex = 1'b1;
				next_state.coll_test = 1'b0;
				next_state.advertise = phy_mgmt_pkg::ADV_RESET_VALUE;
			end else begin
				next_state.restart = pwdata[phy_mgmt_pkg::CTL_RESTART];
				next_state.loopback = pwdata[phy_mgmt_pkg::CTL_LOOPBACK];
				next_state.speed_100 = pwdata[phy_mgmt_pkg::CTL_SPEED];
				next_state.autoneg = pwdata[phy_mgmt_pkg::CTL_AUTONEG];
				next_state.power_down = pwdata[phy_mgmt_pkg::CTL_POWER_DOWN];
				next_state.isolate = pwdata[phy_mgmt_pkg::CTL_ISOLATE];
				next_state.full_duplex = pwdata[phy_mgmt_pkg::CTL_DUPLEX];
				next_state.coll_test = pwdata[phy_mgmt_pkg::CTL_COLL_TEST];
			end
		end
		if (done && pwrite && mapped && idx == phy_mgmt_pkg::IDX_ADVERTISE)
			begin
			// fixed and reserved bits keep their value
			next_state.advertise = (pwdata[15:0]
				& phy_mgmt_pkg::ADV_WRITE_MASK)
				| (state.advertise & ~phy_mgmt_pkg::ADV_WRITE_MASK);
		end
		// forced speed and duplex only without negotiation
		next_state.op_speed_100 = state.autoneg ? negotiated_speed_100
			: state.speed_100;
		next_state.op_full_duplex = state.autoneg ? negotiated_full_duplex
			: state.full_duplex;
		if (srst) begin
			next_state = '0;
			next_state.speed_100 = phy_mgmt_pkg::CTL_RESET_VALUE
				[phy_mgmt_pkg::CTL_SPEED];
			next_state.autoneg = phy_mgmt_pkg::CTL_RESET_VALUE
				[phy_mgmt_pkg::CTL_AUTONEG];
			next_state.full_duplex = phy_mgmt_pkg::CTL_RESET_VALUE
				[phy_mgmt_pkg::CTL_DUPLEX];
			next_state.op_speed_100 = 1'b1;
			next_state.op_full_duplex = 1'b1;
			next_state.advertise = phy_mgmt_pkg::ADV_RESET_VALUE;
			// isolate default follows the strapped address
			next_state.isolate_default = strapped_transceiver_address
				== phy_mgmt_pkg::STRAP_ISOLATE_ADDRESS;
			next_state.isolate = next_state.isolate_default;
		end
	end

	always_ff @(posedge clock) begin
		state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign loopback_en = state.loopback;
	assign power_down = state.power_down;
	assign isolate = state.isolate;
	assign collision_test = state.coll_test;
	assign autoneg_en = state.autoneg;
	assign link_speed_100 = state.op_speed_100;
	assign link_full_duplex = state.op_full_duplex;
	assign soft_reset_pulse = state.soft_reset;
	assign restart_pulse = state.restart;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	sequence s_ctrl_write;
		done && pwrite && mapped && idx == phy_mgmt_pkg::IDX_CONTROL;
	endsequence

	sequence s_status_setup;
		setup && !pwrite && mapped && idx == phy_mgmt_pkg::IDX_STATUS;
	endsequence

	sequence s_reset_write;
		s_ctrl_write ##0 pwdata[phy_mgmt_pkg::CTL_RESET];
	endsequence

	sequence s_control_setup;
		setup && !pwrite && mapped && idx == phy_mgmt_pkg::IDX_CONTROL;
	endsequence

	sequence s_plain_write;
		s_ctrl_write ##0 !pwdata[phy_mgmt_pkg::CTL_RESET];
	endsequence

	sequence s_adv_write;
		done && pwrite && mapped && idx == phy_mgmt_pkg::IDX_ADVERTISE;
	endsequence

	a_map_ready: assert property (setup |=> pready ##1 !pready)
		else $error("ready not one cycle after setup");

	a_bad_address: assert property (setup && !mapped |=>
		pready && pslverr && prdata == 32'h0000_0000)
		else $error("misaligned address not refused");

	a_control_read: assert property (s_control_setup |=>
		prdata[31:16] == 16'h0000 && prdata[6:0] == 7'h00
		&& prdata[phy_mgmt_pkg::CTL_LOOPBACK] == loopback_en
		&& prdata[phy_mgmt_pkg::CTL_AUTONEG] == autoneg_en
		&& prdata[phy_mgmt_pkg::CTL_ISOLATE] == isolate
		&& !prdata[phy_mgmt_pkg::CTL_RESET]
		&& !prdata[phy_mgmt_pkg::CTL_RESTART])
		else $error("control word read wrong");

	a_ident_read: assert property (setup && !pwrite && mapped
		&& idx == phy_mgmt_pkg::IDX_IDENT_HIGH
		|=> prdata[15:0] == IDENT_HIGH)
		else $error("identifier word wrong");

	a_expansion_zero: assert property (setup && !pwrite
		&& idx == phy_mgmt_pkg::IDX_EXPANSION
		|=> prdata == 32'h0000_0000)
		else $error("expansion word not zero");

	a_fixed_status: assert property (s_status_setup |=>
		(prdata[15:11] == 5'b01111) && (prdata[10:6] == 5'b00000)
		&& prdata[3] && prdata[0])
		else $error("fixed status bits wrong");

	a_an_done_shown: assert property (s_status_setup |=>
		prdata[phy_mgmt_pkg::STS_AN_DONE] == $past(autoneg_done))
		else $error("negotiation complete bit wrong");

	a_unsupported_zero: assert property (setup && !pwrite && mapped
		&& idx >= phy_mgmt_pkg::IDX_UNSUPPORTED
		|=> prdata == 32'h0 && !pslverr)
		else $error("reserved index read not zero");

	a_soft_reset_clears: assert property (s_reset_write |=>
		soft_reset_pulse && autoneg_en && !loopback_en
		##1 !soft_reset_pulse)
		else $error("soft reset not self-clearing");

	a_reset_defaults: assert property (s_reset_write |=>
		!power_down && !collision_test
		&& isolate == state.isolate_default)
		else $error("soft reset defaults wrong");

	a_restart_pulse: assert property (s_ctrl_write
		##0 !pwdata[phy_mgmt_pkg::CTL_RESET]
		##0 pwdata[phy_mgmt_pkg::CTL_RESTART] |=> restart_pulse
		##1 !restart_pulse)
		else $error("restart pulse wrong");

	a_loopback_write: assert property (s_plain_write |=>
		loopback_en == $past(pwdata[phy_mgmt_pkg::CTL_LOOPBACK]))
		else $error("loopback not written");

	a_power_write: assert property (s_plain_write |=>
		power_down == $past(pwdata[phy_mgmt_pkg::CTL_POWER_DOWN])
		&& isolate == $past(pwdata[phy_mgmt_pkg::CTL_ISOLATE]))
		else $error("power down or isolate not written");

	a_coll_write: assert property (s_plain_write |=>
		collision_test == $past(pwdata[phy_mgmt_pkg::CTL_COLL_TEST]))
		else $error("collision test not written");

	a_forced_mode: assert property (!autoneg_en && !$past(srst) |=>
		link_speed_100 == $past(state.speed_100)
		&& link_full_duplex == $past(state.full_duplex))
		else $error("forced speed or duplex not applied");

	a_negotiated_mode: assert property (autoneg_en |=>
		link_speed_100 == $past(negotiated_speed_100)
		&& link_full_duplex == $past(negotiated_full_duplex))
		else $error("negotiated speed or duplex not applied");

	a_link_latch_low: assert property (!link_up |=>
		!state.link_latched)
		else $error("link latch did not drop");

	a_link_held_low: assert property (!state.link_latched
		&& !status_read |=> !state.link_latched)
		else $error("link bit rose before a read");

	a_jabber_hold: assert property (jabber_event |=>
		state.jabber_latched)
		else $error("jabber not latched");

	a_jabber_clear: assert property (status_read
		&& state.prdata[phy_mgmt_pkg::STS_JABBER] && !jabber_event
		|=> !state.jabber_latched)
		else $error("jabber not cleared by read");

	a_fault_latch: assert property (remote_fault_event |=>
		state.fault_latched)
		else $error("remote fault not latched");

	a_latch_held: assert property (state.fault_latched
		&& !status_read |=> state.fault_latched)
		else $error("remote fault lost before read");

	a_adv_write: assert property (s_adv_write |=>
		(state.advertise & phy_mgmt_pkg::ADV_WRITE_MASK)
		== ($past(pwdata[15:0]) & phy_mgmt_pkg::ADV_WRITE_MASK))
		else $error("advertise write not applied");

	a_adv_fixed: assert property (
		(state.advertise & ~phy_mgmt_pkg::ADV_WRITE_MASK)
		== (phy_mgmt_pkg::ADV_RESET_VALUE & ~phy_mgmt_pkg::ADV_WRITE_MASK))
		else $error("advertise fixed bits changed");

	a_strap_isolate: assert property (disable iff (1'b0) srst |=>
		isolate == $past(strapped_transceiver_address
		== phy_mgmt_pkg::STRAP_ISOLATE_ADDRESS))
		else $error("isolate default not taken from strap");

endmodule : phy_basic_mgmt_registers

// [verif/apb_host.sv]
// apb master model of the station management controller
`timescale 1ns/1ps
module apb_host (
	input wire logic clock,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		if (wr && a[5:2] == 4'h0)
			d = d & 32'h0000ff80;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		// released bus shows no stale request
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : apb_host

// [verif/tb.sv]
// self-checking bench of the basic management register bank
`timescale 1ns/1ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module tb;
	localparam logic [15:0] sts = phy_mgmt_pkg::STS_FIXED_VALUE;
	logic clock, srst, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [4:0] strap;
	logic link_up, jab, fault, an_done, neg_spd, neg_fd;
	logic [15:0] partner;
	logic [6:0] outs;
	logic sr_p, rs_p;
	int failures, cmp_count, cycles, n_sr, n_rs;

	apb_host i_host (.clock(clock), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	phy_basic_mgmt_registers i_dut (.clock(clock), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strapped_transceiver_address(strap), .link_up(link_up),
		.jabber_event(jab), .remote_fault_event(fault),
		.autoneg_done(an_done), .negotiated_speed_100(neg_spd),
		.negotiated_full_duplex(neg_fd), .partner_word(partner),
		.loopback_en(outs[6]), .power_down(outs[5]), .isolate(outs[4]),
		.collision_test(outs[3]), .autoneg_en(outs[2]),
		.link_speed_100(outs[1]), .link_full_duplex(outs[0]),
		.soft_reset_pulse(sr_p), .restart_pulse(rs_p));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (sr_p === 1'b1)
			n_sr++;
		if (rs_p === 1'b1)
			n_rs++;
		if (cycles == 5000) begin
			failures++;
			stop_test();
		end
	end

	task automatic wr(input logic [3:0] i, input logic [15:0] d);
		i_host.xfer(1'b1, {2'h0, i, 2'h0}, {16'h0, d}, q, e);
	endtask : wr

	task automatic rd(input logic [3:0] i, input logic [15:0] x);
		i_host.xfer(1'b0, {2'h0, i, 2'h0}, 32'h0, q, e);
		`CHK({e, q}, {17'h0, x})
	endtask : rd

	task automatic chk_out(input logic [6:0] x);
		repeat (2) @(posedge clock);
		`CHK(outs, x)
	endtask : chk_out

	task automatic pulse_ev(input bit fl);
		@(posedge clock);
		if (fl) jab <= 1'b1; else fault <= 1'b1;
		@(posedge clock);
		jab <= 1'b0;
		fault <= 1'b0;
	endtask : pulse_ev

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		{srst, strap, link_up, jab, fault, an_done} = {1'b1, 5'h01, 4'h0};
		{neg_spd, neg_fd, partner} = {2'b01, 16'h45e1};
		{failures, cmp_count, cycles, n_sr, n_rs} = 0;
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		rd(4'h0, 16'h3100);
		chk_out(7'b0000101);
		rd(4'h1, sts);
		rd(4'h2, 16'h1234);
		rd(4'h3, 16'h5678);
		rd(4'h4, 16'h01e1);
		rd(4'h5, 16'h45e1);
		rd(4'h6, 16'h0000);
		for (int i = 7; i < 16; i++)
			rd(i[3:0], 16'h0000);
		i_host.xfer(1'b0, 8'h05, 32'h0, q, e);
		`CHK({e, q}, {1'b1, 32'h0})
		$display("test map done");
		wr(4'h1, 16'hffff);
		wr(4'h2, 16'h0000);
		rd(4'h1, sts);
		rd(4'h2, 16'h1234);
		wr(4'h4, 16'hffff);
		rd(4'h4, 16'h25ff);
		wr(4'h0, 16'h4cff);
		rd(4'h0, 16'h4c80);
		chk_out(7'b1111000);
		wr(4'h0, 16'h2100);
		chk_out(7'b0000011);
		wr(4'h0, 16'h1000);
		chk_out(7'b0000101);
		neg_spd <= 1'b1;
		chk_out(7'b0000111);
		wr(4'h0, 16'h1200);
		rd(4'h0, 16'h1000);
		wr(4'h0, 16'hc000);
		rd(4'h0, 16'h3100);
		rd(4'h4, 16'h01e1);
		`CHK({n_sr, n_rs}, {32'd1, 32'd1})
		$display("test control done");
		pulse_ev(1'b1);
		rd(4'h1, sts | 16'h0002);
		rd(4'h1, sts);
		pulse_ev(1'b0);
		rd(4'h1, sts | 16'h0010);
		rd(4'h1, sts);
		link_up <= 1'b1;
		rd(4'h1, sts);
		rd(4'h1, sts | 16'h0004);
		@(posedge clock);
		link_up <= 1'b0;
		@(posedge clock);
		link_up <= 1'b1;
		rd(4'h1, sts);
		an_done <= 1'b1;
		rd(4'h1, sts | 16'h0024);
		$display("test status done");
		@(posedge clock);
		{srst, strap, an_done} <= {1'b1, 5'h00, 1'b0};
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rd(4'h0, 16'h3500);
		rd(4'h1, sts);
		$display("test strap done");
		stop_test();
	end
endmodule : tb
